/* File: verification/wdt_watchdog_tb.sv */
// self-checking bench of the crystal-clocked watchdog
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_watchdog_tb;
   localparam int          T_S    = 64;
   localparam int          T_L    = 256;
   localparam int          DIV    = 2;
   localparam logic [7:0]  VEC_LO = 8'h5a;
   localparam logic [31:0] A_CTRL = 32'(`WDT_IDX_CTRL) << 2;
   localparam logic [31:0] A_STAT = 32'(`WDT_IDX_STATUS) << 2;
   localparam logic [31:0] A_MASK = 32'(`WDT_IDX_MASK) << 2;
   localparam logic [31:0] A_CNT  = 32'(`WDT_IDX_COUNT) << 2;
   localparam logic [31:0] A_SVC  = 32'(`WDT_IDX_SERVICE) << 2;
   localparam logic [31:0] A_BAD  = 32'h0000_0010;

   logic        sys_clk = 1'b0;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        stop_mode;
   logic        stop_exec;
   logic        monitor_mode;
   logic        break_state;
   logic        hv_irq_pin;
   logic        hv_rst_pin;
   logic        internal_reset;
   logic        vector_fetch;
   logic        sys_reset_req;
   logic        rst_pin_out;
   logic        rst_pin_oe;
   logic        irq;
   int          err_total   = 0;
   int          comparisons = 0;
   int          cyc         = 0;

   wdt_watchdog #(.TIMEOUT_SHORT(T_S), .TIMEOUT_LONG(T_L), .POR_CYCLES(16),
      .XTAL_DIV(DIV), .RESET_VECTOR_LO(VEC_LO)) wdt_watchdog_i
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .stop_mode(stop_mode), .stop_exec(stop_exec),
      .monitor_mode(monitor_mode), .break_state(break_state),
      .hv_irq_pin(hv_irq_pin), .hv_rst_pin(hv_rst_pin),
      .internal_reset(internal_reset), .vector_fetch(vector_fetch),
      .sys_reset_req(sys_reset_req), .rst_pin_out(rst_pin_out),
      .rst_pin_oe(rst_pin_oe), .irq(irq)
   );

   always #5 sys_clk = ~sys_clk;

   task automatic final_report;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         err_total++;
      end
   endtask

   // one edge, then until hready is seen high
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1 && n < 50)
      begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask

   // counts cycles with the reset pin pulled low
   task automatic watch(input int k, output int hits);
      hits = 0;
      repeat (k)
      begin
         @(negedge sys_clk);
         if (rst_pin_oe === 1'b1)
            hits++;
      end
   endtask

   task automatic t_init;
      logic [31:0] q;
      logic [31:0] regs [4] = '{A_CTRL, A_STAT, A_MASK, A_BAD};
      repeat (36) @(negedge sys_clk);
      rd(A_CNT, q);
      chk(q[11:3], 32'h0);
      rd(A_SVC, q);
      chk(q, {24'h0, VEC_LO});
      foreach (regs[i])
      begin
         rd(regs[i], q);
         chk(q, 32'h0);
      end
      chk({hresp, irq, rst_pin_oe, sys_reset_req}, 32'h0);
      chk(hreadyout, 1'b1);
   endtask

   task automatic t_overflow(input logic rng);
      logic [31:0] q;
      int          n;
      int          t;
      t = rng ? T_L : T_S;
      wr(A_CTRL, {31'h0, rng});
      wr(A_SVC, 32'h0);
      n = 0;
      while (rst_pin_oe !== 1'b1 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk(n >= (t - 8) * DIV - 4 && n <= t * DIV + 4, 1);
      chk({sys_reset_req, rst_pin_out}, 32'h2);
      n = 0;
      while (rst_pin_oe === 1'b1 && n < 500)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk(n >= 32 * DIV - 2 && n <= 32 * DIV + 2, 1);
      rd(A_STAT, q);
      chk(q, 32'h1);
   endtask

   task automatic t_irq;
      logic [31:0] q;
      chk(irq, 1'b0);
      wr(A_MASK, 32'h1);
      @(negedge sys_clk);
      chk(irq, 1'b1);
      wr(A_STAT, 32'h1);
      @(negedge sys_clk);
      chk(irq, 1'b0);
      rd(A_MASK, q);
      chk(q, 32'h1);
   endtask

   task automatic t_service;
      logic [31:0] q;
      int          h;
      int          tot;
      tot = 0;
      wr(A_CTRL, 32'h0);
      repeat (12)
      begin
         wr(A_SVC, 32'hffff_ffff);
         watch(80, h);
         tot += h;
      end
      chk(tot, 0);
      wr(A_SVC, 32'h0);
      rd(A_CNT, q);
      chk(q[17:4], 32'h0);
   endtask

   task automatic t_disable;
      logic [4:0] cs [6] = '{5'h10, 5'h0a, 5'h09, 5'h05, 5'h06, 5'h00};
      logic       dis;
      int         h;
      foreach (cs[i])
      begin
         dis = cs[i][4] | cs[i][3] & (cs[i][1] | cs[i][0])
            | cs[i][2] & cs[i][0];
         @(posedge sys_clk);
         {monitor_mode, break_state, hv_irq_pin, hv_rst_pin} <= cs[i][3:0];
         wr(A_CTRL, {30'h0, cs[i][4], 1'b0});
         wr(A_SVC, 32'h0);
         watch(300, h);
         chk(h > 0, !dis);
         watch(80, h);
         wr(A_STAT, 32'h1);
      end
      @(posedge sys_clk);
      {monitor_mode, break_state, hv_irq_pin, hv_rst_pin} <= 4'h0;
   endtask

   // runs a while, stops, fires one clear input, reads the count register
   task automatic stop_clear(input int which, output logic [31:0] q);
      repeat (24) @(negedge sys_clk);
      @(posedge sys_clk);
      stop_mode <= 1'b1;
      {stop_exec, vector_fetch, internal_reset} <= 3'(1 << which);
      @(posedge sys_clk);
      {stop_exec, vector_fetch, internal_reset} <= 3'h0;
      rd(A_CNT, q);
   endtask

   task automatic t_stop;
      logic [31:0] a;
      logic [31:0] b;
      while (rst_pin_oe === 1'b1)
         @(negedge sys_clk);
      wr(A_CTRL, 32'h0);
      wr(A_SVC, 32'h0);
      repeat (30) @(negedge sys_clk);
      @(posedge sys_clk);
      stop_mode <= 1'b1;
      rd(A_CNT, a);
      repeat (40) @(negedge sys_clk);
      rd(A_CNT, b);
      chk(b, a);
      chk(a[11:0] != 12'h0, 1);
      @(posedge sys_clk);
      stop_mode <= 1'b0;
      stop_clear(2, b);
      chk(b[11:0], 32'h0);
      stop_mode <= 1'b0;
      stop_clear(1, b);
      chk(b[11:0], 32'h0);
      stop_mode <= 1'b0;
      stop_clear(0, b);
      chk(b, 32'h0);
      stop_mode <= 1'b0;
      wr(A_SVC, 32'h0);
   endtask

   initial
   begin
      rst_n = 1'b0;
      {hsel, htrans, hwrite, hsize} = 7'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      {stop_mode, stop_exec, monitor_mode, break_state} = 4'h0;
      {hv_irq_pin, hv_rst_pin, internal_reset, vector_fetch} = 4'h0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_init();
      t_overflow(1'b0);
      t_irq();
      t_overflow(1'b1);
      t_service();
      t_disable();
      t_stop();
      final_report();
   end
endmodule

/* File: verilog/wdt_params.svh */
// constants of the crystal-clocked watchdog: offsets, fields, counts
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// register indices; byte address is four times the index
`define WDT_IDX_CTRL       16'h0000
`define WDT_IDX_STATUS     16'h0001
`define WDT_IDX_MASK       16'h0002
`define WDT_IDX_COUNT      16'h0003
`define WDT_IDX_SERVICE    16'hffff

// field positions
`define WDT_CTRL_RANGE_BIT 0
`define WDT_CTRL_DIS_BIT   1
`define WDT_STAT_CAUSE_BIT 0

// reset values
`define WDT_CTRL_RESET     2'h0
`define WDT_STATUS_RESET   1'h0
`define WDT_MASK_RESET     1'h0

// lowest prescaler bit cleared by a service write (stage 4)
`define WDT_SVC_CLR_LSB    3

// timing counts in crystal cycles
`define WDT_TIMEOUT_SHORT  8176
`define WDT_TIMEOUT_LONG   262128
`define WDT_RST_PULSE      32
`define WDT_POR_CYCLES     4096

// clock rates
`define WDT_SYS_CLK_HZ     100000000
`define WDT_XTAL_HZ        4915200

`endif

/* File: verilog/wdt_pkg.sv */
// types of the crystal-clocked watchdog
package wdt_pkg;

   typedef enum logic [2:0]
   {
      WDT_REG_NONE,
      WDT_REG_CTRL,
      WDT_REG_STATUS,
      WDT_REG_MASK,
      WDT_REG_COUNT,
      WDT_REG_SERVICE
   } wdt_reg_t;

   typedef enum logic
   {
      WDT_RUN,
      WDT_RESET
   } wdt_state_t;

   typedef struct packed
   {
      logic     valid;
      logic     write;
      wdt_reg_t sel;
   } wdt_req_t;

endpackage

/* File: verilog/wdt_watchdog.sv */
// crystal-clocked watchdog with an ahb-lite register slave
//
// Summary of operation
// - 6-bit counter fed by 12-bit prescaler, crystal ticks only
// - unserviced count overflows after 8176 or 262128 cycles into a reset
// - any service write clears counter and prescaler stages 4-12
// - reading service location returns reset vector low byte, not state
// - watchdog reset drives reset pin low 32 cycles, sets cause flag
// - monitor mode with high voltage on irq or reset pin disables
// - break state with high voltage on reset pin disables watchdog
// - stop instruction clears the prescaler
// - in stop mode crystal ticks are gated; prescaler and counter hold
// - power-on logic clears prescaler 4096 crystal cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears the prescaler
// - disable follows configuration bit; when set no reset is produced
// - no processor interrupt or dma request; outputs are reset and masked status irq
// - keeps counting in wait mode; software services it from a handler
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_watchdog
#(
   parameter int       TIMEOUT_SHORT   = `WDT_TIMEOUT_SHORT,
   parameter int       TIMEOUT_LONG    = `WDT_TIMEOUT_LONG,
   parameter int       POR_CYCLES      = `WDT_POR_CYCLES,
   parameter int       XTAL_DIV        = `WDT_SYS_CLK_HZ / `WDT_XTAL_HZ,
   parameter bit [7:0] RESET_VECTOR_LO = 8'h00
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   input  wire logic        stop_mode,
   input  wire logic        stop_exec,
   input  wire logic        monitor_mode,
   input  wire logic        break_state,
   input  wire logic        hv_irq_pin,
   input  wire logic        hv_rst_pin,
   input  wire logic        internal_reset,
   input  wire logic        vector_fetch,
   output logic             sys_reset_req,
   output logic             rst_pin_out,
   output logic             rst_pin_oe,
   output logic             irq
);

   localparam int PULSE = `WDT_RST_PULSE;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // register decode of an address-phase byte address
   function automatic wdt_pkg::wdt_reg_t reg_sel(input logic [31:0] a);
      if (a[1:0] != 2'b00 || a[31:18] != 14'h0000)
         reg_sel = wdt_pkg::WDT_REG_NONE;
      else
      begin
         case (a[17:2])
            `WDT_IDX_CTRL:    reg_sel = wdt_pkg::WDT_REG_CTRL;
            `WDT_IDX_STATUS:  reg_sel = wdt_pkg::WDT_REG_STATUS;
            `WDT_IDX_MASK:    reg_sel = wdt_pkg::WDT_REG_MASK;
            `WDT_IDX_COUNT:   reg_sel = wdt_pkg::WDT_REG_COUNT;
            `WDT_IDX_SERVICE: reg_sel = wdt_pkg::WDT_REG_SERVICE;
            default:          reg_sel = wdt_pkg::WDT_REG_NONE;
         endcase
      end
   endfunction

   wdt_pkg::wdt_req_t   dp;
   wdt_pkg::wdt_state_t state;
   logic [1:0]          ctrl;
   logic                status;
   logic                mask;
   logic [11:0]         pre;
   logic [5:0]          cnt;
   logic [7:0]          div_cnt;
   logic [4:0]          pulse_cnt;
   logic [12:0]         por_cnt;
   logic                por_done;

   // ---------------- ahb-lite slave ----------------
   wire                 addr_ok = hsel & htrans[1] & hready;
   wire wdt_pkg::wdt_reg_t asel = reg_sel(haddr);
   wire                 wr_now  = dp.valid & dp.write;
   wire                 wr_ctrl = wr_now & (dp.sel == wdt_pkg::WDT_REG_CTRL);
   wire                 wr_stat = wr_now & (dp.sel == wdt_pkg::WDT_REG_STATUS);
   wire                 wr_mask = wr_now & (dp.sel == wdt_pkg::WDT_REG_MASK);
   wire                 svc     = wr_now & (dp.sel == wdt_pkg::WDT_REG_SERVICE);
   wire                 rd_svc  = addr_ok & ~hwrite &
                                  (asel == wdt_pkg::WDT_REG_SERVICE);

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (asel)
         wdt_pkg::WDT_REG_CTRL:    rd_val[1:0]  = ctrl;
         wdt_pkg::WDT_REG_STATUS:  rd_val[0]    = status;
         wdt_pkg::WDT_REG_MASK:    rd_val[0]    = mask;
         wdt_pkg::WDT_REG_COUNT:   rd_val[17:0] = {cnt, pre};
         wdt_pkg::WDT_REG_SERVICE: rd_val[7:0]  = RESET_VECTOR_LO;
         default:                  rd_val       = 32'h0000_0000;
      endcase
   end

   wire wdt_pkg::wdt_req_t next_dp = '{valid: addr_ok, write: hwrite,
                                       sel: asel};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dp     <= '{valid: 1'b0, write: 1'b0, sel: wdt_pkg::WDT_REG_NONE};
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         dp <= next_dp;
         if (addr_ok && !hwrite)
            hrdata <= rd_val;
      end
   end

   // ---------------- crystal tick and disable ----------------
   wire xtal_tick = (div_cnt == 8'(XTAL_DIV - 1));
   wire cnt_tick  = xtal_tick & ~stop_mode;
   wire range_sel = ctrl[`WDT_CTRL_RANGE_BIT];
   wire cfg_dis   = ctrl[`WDT_CTRL_DIS_BIT];
   wire hv_dis    = (monitor_mode & (hv_irq_pin | hv_rst_pin))
                  | (break_state & hv_rst_pin);
   wire disabled  = cfg_dis | hv_dis;
   wire in_rst    = (state == wdt_pkg::WDT_RESET);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_cnt <= 8'h00;
      else if (xtal_tick)
         div_cnt <= 8'h00;
      else
         div_cnt <= div_cnt + 8'h01;
   end

   // ---------------- power-on prescaler clear ----------------
   wire por_clr = ~por_done & xtal_tick &
                  (por_cnt == 13'(POR_CYCLES - 1));

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         por_cnt  <= 13'h0000;
         por_done <= 1'b0;
      end
      else if (por_clr)
         por_done <= 1'b1;
      else if (!por_done && xtal_tick)
         por_cnt <= por_cnt + 13'h0001;
   end

   // ---------------- prescaler and counter ----------------
   wire [17:0] count = {cnt, pre};
   wire [17:0] limit = range_sel ? 18'(TIMEOUT_LONG - 1)
                                 : 18'(TIMEOUT_SHORT - 1);
   wire ovf = cnt_tick & ~disabled & ~in_rst
            & (count == limit);
   wire pre_full_clr = internal_reset | stop_exec
                     | vector_fetch | por_clr
                     | in_rst | ovf;
   wire cnt_clr = internal_reset | svc | disabled
                | in_rst | ovf;
   wire [11:0] svc_keep = 12'((1 << `WDT_SVC_CLR_LSB) - 1);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         pre <= 12'h000;
      else if (pre_full_clr)
         pre <= 12'h000;
      else if (svc)
         pre <= pre & svc_keep;
      else if (cnt_tick)
         pre <= pre + 12'h001;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 6'h00;
      else if (cnt_clr)
         cnt <= 6'h00;
      else if (cnt_tick && pre == 12'hfff)
         cnt <= cnt + 6'h01;
   end

   // ---------------- reset pulse ----------------
   wdt_pkg::wdt_state_t next_state;
   wire pulse_end = xtal_tick & (pulse_cnt == 5'(PULSE - 1));

   always_comb
   begin
      next_state = state;
      case (state)
         wdt_pkg::WDT_RUN:
            if (ovf)
               next_state = wdt_pkg::WDT_RESET;
         wdt_pkg::WDT_RESET:
            if (pulse_end)
               next_state = wdt_pkg::WDT_RUN;
         default:
            next_state = wdt_pkg::WDT_RUN;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= wdt_pkg::WDT_RUN;
         pulse_cnt <= 5'h00;
      end
      else
      begin
         state <= next_state;
         if (!in_rst)
            pulse_cnt <= 5'h00;
         else if (xtal_tick)
            pulse_cnt <= pulse_cnt + 5'h01;
      end
   end

   // reset pin is open drain: only ever pulled low
   assign rst_pin_out   = 1'b0;
   assign rst_pin_oe    = in_rst;
   assign sys_reset_req = in_rst;

   // ---------------- registers ----------------
   wire [1:0] next_ctrl   = wr_ctrl ? hwdata[1:0] : ctrl;
   wire       next_status = (status & ~(wr_stat & hwdata[0])) | ovf;
   wire       next_mask   = wr_mask ? hwdata[0] : mask;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl   <= `WDT_CTRL_RESET;
         status <= `WDT_STATUS_RESET;
         mask   <= `WDT_MASK_RESET;
      end
      else
      begin
         ctrl   <= next_ctrl;
         status <= next_status;
         mask   <= next_mask;
      end
   end

   // status interrupt for the bus side, not a processor request
   assign irq = status & mask;

   // ---------------- assertions ----------------
   sequence s_service;
      svc && !pre_full_clr;
   endsequence

   sequence s_cleared;
      cnt == 6'h00 && (pre & ~svc_keep) == 12'h000;
   endsequence

   property p_service_clear;
      s_service |=> s_cleared;
   endproperty
   a_service_clear: assert property (p_service_clear)
      else $error("service write did not clear the count");

   property p_read_vector;
      rd_svc |=> hrdata == {24'h000000, RESET_VECTOR_LO};
   endproperty
   a_read_vector: assert property (p_read_vector)
      else $error("service read did not return vector byte");

   property p_overflow;
      cnt_tick && !disabled && !in_rst && count == limit
         |=> rst_pin_oe && sys_reset_req && status;
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow did not start the reset");

   property p_pulse_start;
      $rose(rst_pin_oe) |-> pulse_cnt == 5'h00;
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("reset pulse began with a stale count");

   property p_pulse_end;
      rst_pin_oe && xtal_tick && pulse_cnt == 5'(PULSE - 1)
         |=> !rst_pin_oe;
   endproperty
   a_pulse_end: assert property (p_pulse_end)
      else $error("reset pulse not ended after its length");

   property p_pulse_hold;
      $rose(rst_pin_oe) |-> rst_pin_oe [*8];
   endproperty
   a_pulse_hold: assert property (p_pulse_hold)
      else $error("reset pulse too short");

   property p_disabled;
      disabled |=> cnt == 6'h00 && !$rose(rst_pin_oe);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled watchdog kept counting");

   property p_stop_frozen;
      stop_mode && !svc && !pre_full_clr && !cnt_clr
         |=> $stable(pre) && $stable(cnt);
   endproperty
   a_stop_frozen: assert property (p_stop_frozen)
      else $error("count moved in stop mode");

   property p_stop_exec;
      stop_exec |=> pre == 12'h000;
   endproperty
   a_stop_exec: assert property (p_stop_exec)
      else $error("stop did not clear the prescaler");

   property p_internal_reset;
      internal_reset |=> pre == 12'h000 && cnt == 6'h00;
   endproperty
   a_internal_reset: assert property (p_internal_reset)
      else $error("internal reset did not clear the count");

   property p_vector_fetch;
      vector_fetch |=> pre == 12'h000;
   endproperty
   a_vector_fetch: assert property (p_vector_fetch)
      else $error("vector fetch did not clear the prescaler");

   property p_por_clear;
      por_clr |=> pre == 12'h000 && por_done;
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("power-on clear missing");

   property p_cfg_disable;
      cfg_dis |=> !$rose(sys_reset_req);
   endproperty
   a_cfg_disable: assert property (p_cfg_disable)
      else $error("reset while disabled by configuration");

   property p_prescale_step;
      cnt_tick && !pre_full_clr && !svc |=> pre == $past(pre) + 12'h001;
   endproperty
   a_prescale_step: assert property (p_prescale_step)
      else $error("prescaler did not advance on a tick");

   property p_monitor_hv;
      monitor_mode && (hv_irq_pin || hv_rst_pin)
         |=> cnt == 6'h00 && !$rose(sys_reset_req);
   endproperty
   a_monitor_hv: assert property (p_monitor_hv)
      else $error("watchdog ran in monitor mode under high voltage");

   property p_break_hv;
      break_state && hv_rst_pin |=> cnt == 6'h00 && !$rose(sys_reset_req);
   endproperty
   a_break_hv: assert property (p_break_hv)
      else $error("watchdog ran in break state under high voltage");

endmodule
